// ==== rnc_pkg.sv ====
package rnc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [5:0] RNC_OFS_RUN      = 6'h2f;
    localparam logic [5:0] RNC_OFS_LOCK     = 6'h30;
    localparam logic [5:0] RNC_OFS_ID_LO    = 6'h31;
    localparam logic [5:0] RNC_OFS_ID_HI    = 6'h32;
    localparam logic [5:0] RNC_OFS_RSV_A_LO = 6'h33;
    localparam logic [5:0] RNC_OFS_RSV_A_HI = 6'h35;
    localparam logic [5:0] RNC_OFS_MEMCMD   = 6'h36;
    localparam logic [5:0] RNC_OFS_RSV_B_LO = 6'h37;
    localparam logic [5:0] RNC_OFS_RSV_B_HI = 6'h3d;
    localparam logic [5:0] RNC_OFS_TRIM_LO  = 6'h3e;
    localparam logic [5:0] RNC_OFS_TRIM_HI  = 6'h3f;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int         RNC_RUN_BIT      = 0;
    localparam int         RNC_LOCK_W       = 4;
    localparam logic [7:0] RNC_RST_BYTE     = 8'h00;
    localparam logic [15:0] RNC_RST_TRIM    = 16'h0000;

    // ****************************************************************
    // Memory commands
    // ****************************************************************
    localparam logic [7:0] RNC_CMD_STORE    = 8'h2d;
    localparam logic [7:0] RNC_CMD_RECALL   = 8'h59;
    localparam logic [7:0] RNC_CMD_ERASE    = 8'hb8;

    // ****************************************************************
    // Non-volatile word ranges guarded by each lock bit
    // ****************************************************************
    localparam logic [9:0] RNC_R0_LO = 10'd0;
    localparam logic [9:0] RNC_R0_HI = 10'd703;
    localparam logic [9:0] RNC_R1_LO = 10'd704;
    localparam logic [9:0] RNC_R1_HI = 10'd831;
    localparam logic [9:0] RNC_R2_LO = 10'd832;
    localparam logic [9:0] RNC_R2_HI = 10'd959;
    localparam logic [9:0] RNC_R3_LO = 10'd960;
    localparam logic [9:0] RNC_R3_HI = 10'd1007;
    localparam logic [9:0] RNC_R4_LO = 10'd1022;
    localparam logic [9:0] RNC_R4_HI = 10'd1023;

    // ****************************************************************
    // Read-side RAM
    // ****************************************************************
    localparam int         RNC_RD_BYTES     = 35;
    localparam int         RNC_RES_REGS     = 7;
    localparam logic [5:0] RNC_RD_STAT0     = 6'd32;
    localparam logic [5:0] RNC_RD_STAT2     = 6'd34;

    typedef enum logic [1:0] {
        RNC_NV_NONE   = 2'b00,
        RNC_NV_STORE  = 2'b01,
        RNC_NV_RECALL = 2'b10,
        RNC_NV_ERASE  = 2'b11
    } rnc_nvcmd_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } rnc_cfg_req_s;

    typedef struct packed {
        logic       req;
        logic       wr;
        logic [9:0] addr;
    } rnc_nv_req_s;

endpackage

// ==== rnc_nv_guard.sv ====
`timescale 1ns/100ps
// ********************************************************************
// Lock filter for host serial port accesses to non-volatile words
// ********************************************************************
module rnc_nv_guard
    import rnc_pkg::*;
(
    input  wire logic [RNC_LOCK_W-1:0] lock,
    input  rnc_pkg::rnc_nv_req_s        req_in,
    output rnc_pkg::rnc_nv_req_s        req_out,
    output logic                        blocked
);
    logic [RNC_LOCK_W-1:0] hit;

    always_comb begin
        hit[0] = req_in.addr <= RNC_R0_HI;
        hit[1] = (req_in.addr >= RNC_R1_LO) && (req_in.addr <= RNC_R1_HI);
        hit[2] = (req_in.addr >= RNC_R2_LO) && (req_in.addr <= RNC_R2_HI);
        hit[3] = ((req_in.addr >= RNC_R3_LO) && (req_in.addr <= RNC_R3_HI))
               || (req_in.addr >= RNC_R4_LO);
        // Locked ranges refuse both reads and writes
        blocked     = req_in.req && |(hit & lock);
        req_out     = req_in;
        req_out.req = req_in.req && !blocked;
    end

endmodule

// ==== rnc_regs.sv ====
`timescale 1ns/100ps
module rnc_regs
    import rnc_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  rnc_pkg::rnc_cfg_req_s           cfg_req,
    output logic [7:0]                      cfg_rdata,
    input  wire logic                       rd_req,
    input  wire logic [5:0]                 rd_addr,
    output logic [7:0]                      rd_data,
    input  wire logic [RNC_RES_REGS*32-1:0] result_in,
    input  wire logic [7:1]                 status0_in,
    input  wire logic [7:0]                 status1_in,
    input  wire logic [7:0]                 status2_in,
    input  rnc_pkg::rnc_nv_req_s            nv_req_in,
    output rnc_pkg::rnc_nv_req_s            nv_req_out,
    output logic                            nv_blocked,
    input  wire logic                       erase_done,
    output logic                            system_run_switch,
    output logic                            nv_store_en,
    output logic                            nv_recall_en,
    output logic                            nv_erase_go
);
    import rnc_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic                  run;
        logic [RNC_LOCK_W-1:0] lock;
        logic [7:0]            id_lo;
        logic [7:0]            id_hi;
        logic [7:0]            memcmd;
        logic                  cmd_armed;
        logic [15:0]           trim;
        logic [7:0]            cfg_rdata;
        logic [7:0]            rd_data;
        logic                  erase_go;
    } rnc_state_s;

    rnc_state_s s_q;
    rnc_state_s s_d;
    logic       activity;
    logic [7:0] status0;
    rnc_nvcmd_e cmd_kind;

    rnc_nv_guard u_guard (
        .lock    (s_q.lock),
        .req_in  (nv_req_in),
        .req_out (nv_req_out),
        .blocked (nv_blocked)
    );

    // ****************************************************************
    // Command decode
    // ****************************************************************
    always_comb begin
        case (s_q.memcmd)
            RNC_CMD_STORE:  cmd_kind = RNC_NV_STORE;
            RNC_CMD_RECALL: cmd_kind = RNC_NV_RECALL;
            RNC_CMD_ERASE:  cmd_kind = RNC_NV_ERASE;
            default:        cmd_kind = RNC_NV_NONE;
        endcase
    end

    assign activity = cfg_req.wr || cfg_req.rd || rd_req;
    assign status0  = {status0_in, s_q.run};

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d          = s_q;
        s_d.erase_go = 1'b0;
        // Command clears on the first port activity after arming
        if (s_q.cmd_armed && activity) begin
            s_d.memcmd    = RNC_RST_BYTE;
            s_d.cmd_armed = 1'b0;
        end
        if (cfg_req.wr) begin
            case (cfg_req.addr)
                RNC_OFS_RUN: begin
                    s_d.run = cfg_req.wdata[RNC_RUN_BIT];
                end
                RNC_OFS_LOCK: begin
                    s_d.lock = cfg_req.wdata[RNC_LOCK_W-1:0];
                end
                RNC_OFS_ID_LO: begin
                    if (s_q.id_lo == RNC_RST_BYTE) begin
                        s_d.id_lo = cfg_req.wdata;
                    end
                end
                RNC_OFS_ID_HI: begin
                    if (s_q.id_hi == RNC_RST_BYTE) begin
                        s_d.id_hi = cfg_req.wdata;
                    end
                end
                RNC_OFS_MEMCMD: begin
                    s_d.memcmd    = cfg_req.wdata;
                    s_d.cmd_armed = 1'b1;
                    s_d.erase_go  = cfg_req.wdata == RNC_CMD_ERASE;
                end
                RNC_OFS_TRIM_LO: begin
                    s_d.trim[7:0] = cfg_req.wdata;
                end
                RNC_OFS_TRIM_HI: begin
                    s_d.trim[15:8] = cfg_req.wdata;
                end
                default: begin
                end
            endcase
        end
        // Complete erase wipes the identification bytes
        if (erase_done) begin
            s_d.id_lo = RNC_RST_BYTE;
            s_d.id_hi = RNC_RST_BYTE;
        end
        if (cfg_req.rd) begin
            case (cfg_req.addr)
                RNC_OFS_RUN:     s_d.cfg_rdata = {7'h00, s_q.run};
                RNC_OFS_LOCK:    s_d.cfg_rdata = {4'h0, s_q.lock};
                RNC_OFS_ID_LO:   s_d.cfg_rdata = s_q.id_lo;
                RNC_OFS_ID_HI:   s_d.cfg_rdata = s_q.id_hi;
                RNC_OFS_MEMCMD:  s_d.cfg_rdata = s_q.memcmd;
                RNC_OFS_TRIM_LO: s_d.cfg_rdata = s_q.trim[7:0];
                RNC_OFS_TRIM_HI: s_d.cfg_rdata = s_q.trim[15:8];
                default:         s_d.cfg_rdata = RNC_RST_BYTE;
            endcase
        end
        if (rd_req) begin
            if (rd_addr == RNC_RD_STAT0) begin
                s_d.rd_data = status0;
            end else if (rd_addr == RNC_RD_STAT0 + 6'd1) begin
                s_d.rd_data = status1_in;
            end else if (rd_addr == RNC_RD_STAT2) begin
                s_d.rd_data = status2_in;
            end else if (rd_addr < RNC_RD_STAT0 - 6'd4) begin
                s_d.rd_data = result_in[{rd_addr[4:0], 3'b000} +: 8];
            end else begin
                s_d.rd_data = RNC_RST_BYTE;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg_rdata         = s_q.cfg_rdata;
    assign rd_data           = s_q.rd_data;
    assign system_run_switch = s_q.run;
    assign nv_store_en       = cmd_kind == RNC_NV_STORE;
    assign nv_recall_en      = cmd_kind == RNC_NV_RECALL;
    assign nv_erase_go       = s_q.erase_go;

    // ****************************************************************
    // Checks
    // ****************************************************************
    run_follow_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_req.wr && cfg_req.addr == RNC_OFS_RUN |=> system_run_switch == $past(cfg_req.wdata[0]))
        else $error("run switch did not follow write");
    lock_block_a: assert property (@(posedge clk) disable iff (!resetn)
        nv_req_in.req && s_q.lock[0] && nv_req_in.addr <= RNC_R0_HI |-> !nv_req_out.req)
        else $error("locked range 0 passed");
    lock_high_a: assert property (@(posedge clk) disable iff (!resetn)
        nv_req_in.req && s_q.lock[3] && nv_req_in.addr >= RNC_R4_LO |-> nv_blocked)
        else $error("locked top words passed");
    lock_pass_a: assert property (@(posedge clk) disable iff (!resetn)
        nv_req_in.req && s_q.lock == 4'h0 |-> nv_req_out.req && !nv_blocked)
        else $error("unlocked access refused");
    id_once_a: assert property (@(posedge clk) disable iff (!resetn)
        s_q.id_lo != 8'h00 && !erase_done |=> s_q.id_lo == $past(s_q.id_lo))
        else $error("id byte overwritten");
    cmd_decode_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_req.wr && cfg_req.addr == RNC_OFS_MEMCMD && cfg_req.wdata == RNC_CMD_STORE
        && !erase_done |=> nv_store_en)
        else $error("store not enabled");
    cmd_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        s_q.cmd_armed && (cfg_req.wr || cfg_req.rd || rd_req)
        && !(cfg_req.wr && cfg_req.addr == RNC_OFS_MEMCMD) |=> s_q.memcmd == 8'h00)
        else $error("command not cleared");
    stat_run_a: assert property (@(posedge clk) disable iff (!resetn)
        rd_req && rd_addr == RNC_RD_STAT0 |=> rd_data[0] == $past(s_q.run))
        else $error("status mirror wrong");
    id_hi_once_a: assert property (@(posedge clk) disable iff (!resetn)
        s_q.id_hi != 8'h00 && !erase_done |=> s_q.id_hi == $past(s_q.id_hi))
        else $error("id high byte overwritten");
    erase_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
        nv_erase_go
        && !(cfg_req.wr && cfg_req.addr == RNC_OFS_MEMCMD && cfg_req.wdata == RNC_CMD_ERASE)
        |=> !nv_erase_go)
        else $error("erase start longer than one cycle");
    stat_one_a: assert property (@(posedge clk) disable iff (!resetn)
        rd_req && rd_addr == RNC_RD_STAT0 + 6'd1 |=> rd_data == $past(status1_in))
        else $error("status byte 1 wrong");
    gap_open_a: assert property (@(posedge clk) disable iff (!resetn)
        nv_req_in.req && nv_req_in.addr > RNC_R3_HI && nv_req_in.addr < RNC_R4_LO
        |-> !nv_blocked)
        else $error("unguarded words refused");
    unused_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_req.rd && cfg_req.addr == RNC_OFS_LOCK |=> cfg_rdata[7:4] == 4'h0)
        else $error("unused lock bits nonzero");
    res_read_a: assert property (@(posedge clk) disable iff (!resetn)
        rd_req && rd_addr == 6'd0 |=> rd_data == $past(result_in[7:0]))
        else $error("result byte wrong");

    run_on_c:   cover property (@(posedge clk) disable iff (!resetn) system_run_switch);
    erase_c:    cover property (@(posedge clk) disable iff (!resetn) nv_erase_go);
    store_c:    cover property (@(posedge clk) disable iff (!resetn) nv_store_en);
    blocked_c:  cover property (@(posedge clk) disable iff (!resetn) nv_blocked);
    cmd_clr_c:  cover property (@(posedge clk) disable iff (!resetn)
        nv_recall_en ##1 !nv_recall_en);

endmodule

// ==== rnc_host_model.sv ====
`timescale 1ns/100ps
// ****************************************************************
// Host controller on the serial configuration port
// ****************************************************************
module rnc_host_model (
    input  wire logic             clk,
    output rnc_pkg::rnc_cfg_req_s cfg_req
);
    import rnc_pkg::*;
    logic run_on = 1'b0;
    initial cfg_req = '0;
    task automatic bus(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
        repeat ($urandom_range(1, 0)) @(posedge clk);
        @(posedge clk) cfg_req <= '{w, r, a, d};
        @(posedge clk) cfg_req <= '0;
    endtask
    task automatic wr_byte(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a inside {[RNC_OFS_RSV_A_LO:RNC_OFS_RSV_A_HI]}) v = 8'h00;
        if (a inside {[RNC_OFS_RSV_B_LO:RNC_OFS_RSV_B_HI]}) v = 8'h00;
        if (a == RNC_OFS_TRIM_LO || a == RNC_OFS_TRIM_HI) return;
        if (run_on && a != RNC_OFS_RUN) begin
            bus(1'b1, 1'b0, RNC_OFS_RUN, 8'h00);
            run_on = 1'b0;
        end
        if (a == RNC_OFS_RUN) run_on = v[0];
        bus(1'b1, 1'b0, a, v);
    endtask
    task automatic rd_byte(input logic [5:0] a);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    // Erase is started by the command write, preceded by a run switch-off write when run_on is set
    task automatic erase_nv();
        wr_byte(RNC_OFS_MEMCMD, RNC_CMD_ERASE);
    endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    import rnc_pkg::*;
    logic                       clk, resetn, rd_req, erase_done, probe, cfg_seen, ram_seen;
    logic                       nv_blocked, system_run_switch;
    logic                       nv_store_en, nv_recall_en, nv_erase_go;
    rnc_cfg_req_s               cfg_req;
    rnc_nv_req_s                nv_req_in, nv_req_out;
    logic [5:0]                 rd_addr;
    logic [7:0]                 cfg_rdata, rd_data, status1_in, status2_in, got, v, x;
    logic [7:1]                 status0_in;
    logic [RNC_RES_REGS*32-1:0] result_in;
    logic [9:0]                 exp_q[$];
    logic [9:0]                 e;
    int                         bad_count = 0, num_checks = 0, er_cnt = 0;
    logic [9:0] nva[12] = '{10'd0, 10'd703, 10'd704, 10'd831, 10'd832, 10'd959,
                            10'd960, 10'd1007, 10'd1022, 10'd1023, 10'd1008, 10'd1021};
    int         own[12] = '{0, 0, 1, 1, 2, 2, 3, 3, 3, 3, 9, 9};
    logic [5:0] ofs[9]  = '{RNC_OFS_RUN, RNC_OFS_LOCK, RNC_OFS_ID_LO, RNC_OFS_ID_HI,
                            RNC_OFS_RSV_A_LO, RNC_OFS_MEMCMD, RNC_OFS_RSV_B_HI,
                            RNC_OFS_TRIM_LO, RNC_OFS_TRIM_HI};
    logic [7:0] cmd[4]  = '{RNC_CMD_STORE, RNC_CMD_RECALL, RNC_CMD_ERASE, 8'h11};
    logic [7:0] cme[4]  = '{8'h0a, 8'h09, 8'h08, 8'h08};

    rnc_host_model host_u (.clk(clk), .cfg_req(cfg_req));
    rnc_regs dut_u (.clk(clk), .resetn(resetn), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .result_in(result_in),
        .status0_in(status0_in), .status1_in(status1_in), .status2_in(status2_in),
        .nv_req_in(nv_req_in), .nv_req_out(nv_req_out), .nv_blocked(nv_blocked),
        .erase_done(erase_done), .system_run_switch(system_run_switch),
        .nv_store_en(nv_store_en), .nv_recall_en(nv_recall_en), .nv_erase_go(nv_erase_go));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ****************************************************************
    // Result watcher
    // ****************************************************************
    always @(posedge clk) begin
        cfg_seen <= cfg_req.rd;
        ram_seen <= rd_req;
    end
    always @(negedge clk) begin
        if (nv_erase_go === 1'b1) er_cnt <= er_cnt + 1;
        if (cfg_seen || ram_seen || probe) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3ff;
            case (e[9:8])
                2'd0: got = cfg_rdata;
                2'd1: got = rd_data;
                2'd2: got = {3'b000, nv_blocked, nv_req_out.req, system_run_switch,
                             nv_store_en, nv_recall_en};
                default: got = er_cnt[7:0];
            endcase
            num_checks++;
            if (got !== e[7:0]) begin
                bad_count++;
                $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e[7:0], got);
            end
        end
    end

    // ****************************************************************
    // Drivers
    // ****************************************************************
    task automatic rd_cfg(input logic [5:0] a, input logic [7:0] xv);
        exp_q.push_back({2'd0, xv});
        host_u.rd_byte(a);
    endtask
    task automatic rd_ram(input logic [5:0] a, input logic [7:0] xv);
        exp_q.push_back({2'd1, xv});
        @(posedge clk) begin
            rd_req <= 1'b1;
            rd_addr <= a;
        end
        @(posedge clk) begin
            rd_req <= 1'b0;
            rd_addr <= ~a;
        end
    endtask
    task automatic chk(input logic [1:0] k, input logic [7:0] xv, input logic [9:0] na);
        exp_q.push_back({k, xv});
        @(posedge clk) begin
            probe <= 1'b1;
            nv_req_in <= '{1'b1, 1'($urandom()), na};
        end
        @(posedge clk) begin
            probe <= 1'b0;
            nv_req_in <= '{1'b0, 1'b0, ~na};
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'hb8e4ff83));
        resetn = 1'b0;
        rd_req = 1'b0;
        rd_addr = '0;
        erase_done = 1'b0;
        probe = 1'b0;
        nv_req_in = '0;
        for (int i = 0; i < RNC_RES_REGS; i++) result_in[i*32 +: 32] = $urandom();
        status0_in = 7'($urandom());
        status1_in = 8'($urandom());
        status2_in = 8'($urandom());
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        foreach (ofs[i]) rd_cfg(ofs[i], 8'h00);
        chk(2'd2, 8'h08, 10'd1008);
        host_u.wr_byte(RNC_OFS_RUN, 8'hff);
        chk(2'd2, 8'h0c, 10'd1008);
        rd_cfg(RNC_OFS_RUN, 8'h01);
        rd_ram(RNC_RD_STAT0, {status0_in, 1'b1});
        host_u.wr_byte(RNC_OFS_RUN, 8'h00);
        rd_ram(RNC_RD_STAT0, {status0_in, 1'b0});
        for (int b = 0; b < RNC_LOCK_W; b++) begin
            host_u.wr_byte(RNC_OFS_LOCK, 8'hf0 | (8'h01 << b));
            rd_cfg(RNC_OFS_LOCK, 8'h01 << b);
            foreach (nva[i]) chk(2'd2, (own[i] == b) ? 8'h10 : 8'h08, nva[i]);
        end
        host_u.wr_byte(RNC_OFS_LOCK, 8'h00);
        for (int i = 0; i < 2; i++) begin
            v = 8'($urandom_range(255, 1));
            host_u.wr_byte(ofs[2+i], v);
            host_u.wr_byte(ofs[2+i], ~v);
            rd_cfg(ofs[2+i], v);
        end
        @(posedge clk) erase_done <= 1'b1;
        @(posedge clk) erase_done <= 1'b0;
        rd_cfg(RNC_OFS_ID_LO, 8'h00);
        host_u.wr_byte(RNC_OFS_ID_HI, 8'h3c);
        rd_cfg(RNC_OFS_ID_HI, 8'h3c);
        foreach (cmd[i]) begin
            if (i == 2) host_u.erase_nv();
            else host_u.wr_byte(RNC_OFS_MEMCMD, cmd[i]);
            chk(2'd2, cme[i], 10'd1008);
            if (i == 1) rd_cfg(RNC_OFS_MEMCMD, cmd[i]);
            rd_ram(6'd63, 8'h00);
            chk(2'd2, 8'h08, 10'd1008);
            rd_cfg(RNC_OFS_MEMCMD, 8'h00);
        end
        chk(2'd3, 8'h01, 10'd0);
        for (int a = 0; a < RNC_RD_BYTES; a++) begin
            x = (a < 28) ? result_in[a*8 +: 8] : (a == 32) ? {status0_in, 1'b0} :
                (a == 33) ? status1_in : (a == 34) ? status2_in : 8'h00;
            rd_ram(6'(a), x);
        end
        repeat (3) @(posedge clk);
        if (exp_q.size() != 0) bad_count++;
        give_verdict();
    end
endmodule
